// ### design/slcr_defines.svh
// Offsets, field positions, reset values and rate figures of the lane
// configuration bank. Assumes the includer uses them with a 32-bit APB.
//
// Behaviour
// - Tx half-rate bit set: serial x8, byte clock ref/4; clear: x16, ref/2.
// - Reset loads every transmit configuration register with zero.
// - Tx power-down bit drives that lane's transmit power-down control.
// - Emphasis bits: both clear 0%, one set 12.5%, both set 25%.
// - Half-swing bit asks the transmit buffer for half amplitude.
// - Rx half-rate bit set: serial x8, byte clock ref/4; clear: x16, ref/2.
// - Rx power-down bit drives that lane's receive power-down; resets clear.
// - Reset loads every receive configuration register with hex 20.
`ifndef SLCR_DEFINES_SVH
`define SLCR_DEFINES_SVH

// Register indices; byte address is four times the index
`define SLCR_TX_IDX_AA 18'h3_0002
`define SLCR_RX_IDX_AA 18'h3_0003
`define SLCR_TX_IDX_AB 18'h3_0012
`define SLCR_RX_IDX_AB 18'h3_0013
`define SLCR_TX_IDX_AC 18'h3_0022
`define SLCR_RX_IDX_AC 18'h3_0023
`define SLCR_TX_IDX_AD 18'h3_0032
`define SLCR_RX_IDX_AD 18'h3_0033
`define SLCR_TX_IDX_BA 18'h3_0102
`define SLCR_RX_IDX_BA 18'h3_0103
`define SLCR_TX_IDX_BB 18'h3_0112
`define SLCR_RX_IDX_BB 18'h3_0113
`define SLCR_TX_IDX_BC 18'h3_0122
`define SLCR_RX_IDX_BC 18'h3_0123
`define SLCR_TX_IDX_BD 18'h3_0132
`define SLCR_RX_IDX_BD 18'h3_0133

// Field positions; documented bit 0 is the most significant data bit
`define SLCR_TX_HALF_RATE_BIT 7
`define SLCR_TX_PWR_DOWN_BIT  6
`define SLCR_TX_EMPH_LO_BIT   5
`define SLCR_TX_EMPH_HI_BIT   4
`define SLCR_TX_HALF_SWING_BIT 3
`define SLCR_RX_HALF_RATE_BIT 7
`define SLCR_RX_PWR_DOWN_BIT  6

`define SLCR_TX_RESET 8'h00
`define SLCR_RX_RESET 8'h20

// Serial rate as a multiple of the reference, byte clock as its divisor
`define SLCR_MULT_HALF 5'h08
`define SLCR_MULT_FULL 5'h10
`define SLCR_DIV_HALF  3'h4
`define SLCR_DIV_FULL  3'h2

`endif

// ### design/slcr_pkg.sv
// Types shared by the lane configuration bank and its users.
// Assumes nothing of its surroundings.
package slcr_pkg;

    typedef enum logic [1:0] {
        SLCR_EMPH_0PCT    = 2'h0,
        SLCR_EMPH_12P5PCT = 2'h1,
        SLCR_EMPH_25PCT   = 2'h3
    } slcr_emph_t;

    typedef struct packed {
        logic       tx_half_rate_sel;
        logic [4:0] tx_serial_mult;
        logic [2:0] tx_byte_div;
        logic       tx_power_down;
        logic       tx_emph_sel_hi;
        logic       tx_emph_sel_lo;
        slcr_emph_t tx_emph_level;
        logic       tx_half_swing;
        logic       rx_half_rate_sel;
        logic [4:0] rx_serial_mult;
        logic [2:0] rx_byte_div;
        logic       rx_power_down;
    } slcr_lane_ctl_t;

endpackage

// ### design/slcr_regs.sv
// Per-lane transmit and receive configuration registers behind an APB
// slave, with the decoded lane controls driven from flip-flops.
// Assumes APB signals synchronous to CLK_IN and the analog lanes
// reading LANE_CTL_OUT as static levels.
`timescale 1ns/1ps
`default_nettype none
`include "slcr_defines.svh"

module slcr_regs #(
    parameter int NUM_LANES = 8
) (
    input  wire logic                                  CLK_IN,       // System clock
    input  wire logic                                  RST_N_IN,     // Async reset, low
    input  wire logic                                  PSEL_IN,      // APB select
    input  wire logic                                  PENABLE_IN,   // APB access phase
    input  wire logic                                  PWRITE_IN,    // APB write
    input  wire logic [19:0]                           PADDR_IN,     // APB byte address
    input  wire logic [31:0]                           PWDATA_IN,    // APB write data
    input  wire logic [3:0]                            PSTRB_IN,     // APB byte strobes
    output logic                                       PREADY_OUT,   // APB ready
    output logic [31:0]                                PRDATA_OUT,   // APB read data
    output logic                                       PSLVERR_OUT,  // APB error
    output slcr_pkg::slcr_lane_ctl_t [NUM_LANES-1:0]   LANE_CTL_OUT  // Lane controls
);

    localparam logic [17:0] TX_IDX [8] = '{
        `SLCR_TX_IDX_AA, `SLCR_TX_IDX_AB, `SLCR_TX_IDX_AC, `SLCR_TX_IDX_AD,
        `SLCR_TX_IDX_BA, `SLCR_TX_IDX_BB, `SLCR_TX_IDX_BC, `SLCR_TX_IDX_BD
    };
    localparam logic [17:0] RX_IDX [8] = '{
        `SLCR_RX_IDX_AA, `SLCR_RX_IDX_AB, `SLCR_RX_IDX_AC, `SLCR_RX_IDX_AD,
        `SLCR_RX_IDX_BA, `SLCR_RX_IDX_BB, `SLCR_RX_IDX_BC, `SLCR_RX_IDX_BD
    };

    if (NUM_LANES < 1 || NUM_LANES > 8) begin : g_bad_lanes
        $error("NUM_LANES must lie between 1 and 8");
    end

    logic [7:0]                              tx_cfg       [NUM_LANES];
    logic [7:0]                              rx_cfg       [NUM_LANES];
    logic [7:0]                              next_tx_cfg  [NUM_LANES];
    logic [7:0]                              next_rx_cfg  [NUM_LANES];
    logic [NUM_LANES-1:0]                    hit_tx;
    logic [NUM_LANES-1:0]                    hit_rx;
    logic [17:0]                             reg_idx;
    logic                                    aligned;
    logic                                    any_hit;
    logic                                    setup_phase;
    logic                                    access_phase;
    logic                                    low_byte_write;
    logic [7:0]                              read_mux;
    logic [31:0]                             prdata;
    logic [31:0]                             next_prdata;
    logic                                    pslverr;
    logic                                    next_pslverr;
    slcr_pkg::slcr_lane_ctl_t [NUM_LANES-1:0] lane_ctl;
    slcr_pkg::slcr_lane_ctl_t [NUM_LANES-1:0] next_lane_ctl;

    assign reg_idx        = PADDR_IN[19:2];
    assign aligned        = (PADDR_IN[1:0] == 2'h0);
    assign setup_phase    = PSEL_IN & ~PENABLE_IN;
    assign access_phase   = PSEL_IN & PENABLE_IN;
    // Registers are eight bits wide, so only the low byte strobe matters
    assign low_byte_write = access_phase & PWRITE_IN & PSTRB_IN[0];
    assign any_hit        = |{hit_tx, hit_rx};

    // Read data and error are caught in the setup cycle, so the access
    // phase can answer at once from flip-flops without a wait state.
    assign PREADY_OUT  = access_phase;
    assign PRDATA_OUT  = prdata;
    assign PSLVERR_OUT = pslverr;
    assign LANE_CTL_OUT = lane_ctl;

    always_comb begin
        read_mux = 8'h00;
        for (int i = 0; i < NUM_LANES; i++) begin
            if (hit_tx[i]) begin
                read_mux = tx_cfg[i];
            end
            if (hit_rx[i]) begin
                read_mux = rx_cfg[i];
            end
        end
    end

    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_prdata  = PWRITE_IN ? 32'h0000_0000 : {24'h00_0000, read_mux};
            next_pslverr = ~any_hit;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign hit_tx[g] = aligned && (reg_idx == TX_IDX[g]);
        assign hit_rx[g] = aligned && (reg_idx == RX_IDX[g]);

        always_comb begin
            next_tx_cfg[g] = tx_cfg[g];
            next_rx_cfg[g] = rx_cfg[g];
            if (low_byte_write && hit_tx[g]) begin
                next_tx_cfg[g] = PWDATA_IN[7:0];
            end
            if (low_byte_write && hit_rx[g]) begin
                next_rx_cfg[g] = PWDATA_IN[7:0];
            end
        end

        always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                tx_cfg[g] <= `SLCR_TX_RESET;
                rx_cfg[g] <= `SLCR_RX_RESET;
            end else begin
                tx_cfg[g] <= next_tx_cfg[g];
                rx_cfg[g] <= next_rx_cfg[g];
            end
        end

        always_comb begin
            logic tx_hr;
            logic rx_hr;
            logic e_hi;
            logic e_lo;
            tx_hr = tx_cfg[g][`SLCR_TX_HALF_RATE_BIT];
            rx_hr = rx_cfg[g][`SLCR_RX_HALF_RATE_BIT];
            e_hi  = tx_cfg[g][`SLCR_TX_EMPH_HI_BIT];
            e_lo  = tx_cfg[g][`SLCR_TX_EMPH_LO_BIT];
            next_lane_ctl[g].tx_half_rate_sel = tx_hr;
            next_lane_ctl[g].tx_serial_mult   = tx_hr ? `SLCR_MULT_HALF : `SLCR_MULT_FULL;
            next_lane_ctl[g].tx_byte_div      = tx_hr ? `SLCR_DIV_HALF : `SLCR_DIV_FULL;
            next_lane_ctl[g].tx_power_down    = tx_cfg[g][`SLCR_TX_PWR_DOWN_BIT];
            next_lane_ctl[g].tx_emph_sel_hi   = e_hi;
            next_lane_ctl[g].tx_emph_sel_lo   = e_lo;
            case ({e_hi, e_lo})
                2'b00:   next_lane_ctl[g].tx_emph_level = slcr_pkg::SLCR_EMPH_0PCT;
                2'b11:   next_lane_ctl[g].tx_emph_level = slcr_pkg::SLCR_EMPH_25PCT;
                default: next_lane_ctl[g].tx_emph_level = slcr_pkg::SLCR_EMPH_12P5PCT;
            endcase
            next_lane_ctl[g].tx_half_swing    = tx_cfg[g][`SLCR_TX_HALF_SWING_BIT];
            next_lane_ctl[g].rx_half_rate_sel = rx_hr;
            next_lane_ctl[g].rx_serial_mult   = rx_hr ? `SLCR_MULT_HALF : `SLCR_MULT_FULL;
            next_lane_ctl[g].rx_byte_div      = rx_hr ? `SLCR_DIV_HALF : `SLCR_DIV_FULL;
            next_lane_ctl[g].rx_power_down    = rx_cfg[g][`SLCR_RX_PWR_DOWN_BIT];
        end

        always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                lane_ctl[g].tx_half_rate_sel <= 1'b0;
                lane_ctl[g].tx_serial_mult   <= `SLCR_MULT_FULL;
                lane_ctl[g].tx_byte_div      <= `SLCR_DIV_FULL;
                lane_ctl[g].tx_power_down    <= 1'b0;
                lane_ctl[g].tx_emph_sel_hi   <= 1'b0;
                lane_ctl[g].tx_emph_sel_lo   <= 1'b0;
                lane_ctl[g].tx_emph_level    <= slcr_pkg::SLCR_EMPH_0PCT;
                lane_ctl[g].tx_half_swing    <= 1'b0;
                lane_ctl[g].rx_half_rate_sel <= 1'b0;
                lane_ctl[g].rx_serial_mult   <= `SLCR_MULT_FULL;
                lane_ctl[g].rx_byte_div      <= `SLCR_DIV_FULL;
                lane_ctl[g].rx_power_down    <= 1'b0;
            end else begin
                lane_ctl[g] <= next_lane_ctl[g];
            end
        end
    end

endmodule

`default_nettype wire

// ### tb/slcr_regs_assertions.sv
// Port checks for the lane configuration bank, watching lane AA closely.
// Assumes a bind onto slcr_regs and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module slcr_regs_assertions #(
    parameter int NUM_LANES = 8
) (
    input wire logic                                CLK_IN,       // Clock
    input wire logic                                RST_N_IN,     // Reset, low
    input wire logic                                PSEL_IN,      // Select
    input wire logic                                PENABLE_IN,   // Access
    input wire logic                                PWRITE_IN,    // Write
    input wire logic [19:0]                         PADDR_IN,     // Address
    input wire logic [31:0]                         PWDATA_IN,    // Write data
    input wire logic [3:0]                          PSTRB_IN,     // Strobes
    input wire logic                                PREADY_OUT,   // Ready
    input wire logic [31:0]                         PRDATA_OUT,   // Read data
    input wire logic                                PSLVERR_OUT,  // Error
    input wire slcr_pkg::slcr_lane_ctl_t [NUM_LANES-1:0] LANE_CTL_OUT  // Controls
);
    slcr_pkg::slcr_lane_ctl_t c0;
    logic                     wr_hit;
    logic [4:0]               wtx;
    logic [1:0]               wrx;
    assign c0 = LANE_CTL_OUT[0];
    assign wr_hit = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0];
    assign wtx = PWDATA_IN[7:3];
    assign wrx = PWDATA_IN[7:6];
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_ready; PREADY_OUT == (PSEL_IN && PENABLE_IN); endproperty
    a_ready: assert property (p_ready) else $error("ready not zero wait");
    property p_tx_rate; c0.tx_serial_mult == (c0.tx_half_rate_sel ? 5'h08 : 5'h10)
        && c0.tx_byte_div == (c0.tx_half_rate_sel ? 3'h4 : 3'h2); endproperty
    a_tx_rate: assert property (p_tx_rate) else $error("tx rate fields wrong");
    property p_rx_rate; c0.rx_serial_mult == (c0.rx_half_rate_sel ? 5'h08 : 5'h10)
        && c0.rx_byte_div == (c0.rx_half_rate_sel ? 3'h4 : 3'h2); endproperty
    a_rx_rate: assert property (p_rx_rate) else $error("rx rate fields wrong");
    property p_emph; c0.tx_emph_level == {c0.tx_emph_sel_hi & c0.tx_emph_sel_lo,
        c0.tx_emph_sel_hi | c0.tx_emph_sel_lo}; endproperty
    a_emph: assert property (p_emph) else $error("emphasis level wrong");
    property p_tx_write; wr_hit && PADDR_IN == 20'hC_0008 |-> ##2 {c0.tx_half_rate_sel, c0.tx_power_down,
        c0.tx_emph_sel_lo, c0.tx_emph_sel_hi, c0.tx_half_swing} == $past(wtx, 2); endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx controls not from write");
    property p_rx_write; wr_hit && PADDR_IN == 20'hC_000C |-> ##2
        {c0.rx_half_rate_sel, c0.rx_power_down} == $past(wrx, 2); endproperty
    a_rx_write: assert property (p_rx_write) else $error("rx controls not from write");
    property p_err; PSEL_IN && !PENABLE_IN && PADDR_IN == 20'h0_0000 |=>
        PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_rd_hi; PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h00_0000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
endmodule
`default_nettype wire

// ### tb/slcr_regs_test.sv
// Self-checking bench for the lane configuration bank over APB.
// Assumes zero-wait APB answers and lane controls two edges after a write.
`timescale 1ns/1ps
`default_nettype none
module slcr_regs_test;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pready, pslverr, er;
    logic [19:0] paddr = 20'h0_0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic [7:0] tp[8], rp[8];
    slcr_pkg::slcr_lane_ctl_t [7:0] lane_ctl;
    int bad_count = 0, cmp_count = 0;
    always #5 clk = ~clk;
    slcr_regs #(.NUM_LANES(8)) slcr_regs_i (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .LANE_CTL_OUT(lane_ctl));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task chk_ctl(input string nm, input slcr_pkg::slcr_lane_ctl_t exp, input slcr_pkg::slcr_lane_ctl_t got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task chk_err(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled high
    task apb(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [19:0] adr(input int i, input logic rx);
        return {18'h3_0002 + (i[2] ? 18'h0_0100 : 18'h0_0000) + 18'(i % 4) * 18'h0_0010 + 18'(rx), 2'h0};
    endfunction
    function automatic slcr_pkg::slcr_lane_ctl_t exp_ctl(input logic [7:0] t, input logic [7:0] r);
        exp_ctl.tx_half_rate_sel = t[7];
        exp_ctl.tx_serial_mult = t[7] ? 5'h08 : 5'h10;
        exp_ctl.tx_byte_div = t[7] ? 3'h4 : 3'h2;
        exp_ctl.rx_half_rate_sel = r[7];
        exp_ctl.rx_serial_mult = r[7] ? 5'h08 : 5'h10;
        exp_ctl.rx_byte_div = r[7] ? 3'h4 : 3'h2;
        exp_ctl.tx_power_down = t[6];
        exp_ctl.rx_power_down = r[6];
        exp_ctl.tx_emph_sel_lo = t[5];
        exp_ctl.tx_emph_sel_hi = t[4];
        exp_ctl.tx_emph_level = (t[5] & t[4]) ? slcr_pkg::SLCR_EMPH_25PCT
            : (t[5] | t[4]) ? slcr_pkg::SLCR_EMPH_12P5PCT : slcr_pkg::SLCR_EMPH_0PCT;
        exp_ctl.tx_half_swing = t[3];
    endfunction
    task t_reset;
        for (int i = 0; i < 8; i++) begin
            apb(1'h0, adr(i, 1'h0), 32'h0000_0000, 4'h0);
            chk("tx reset", 32'h0000_0000, rd);
            apb(1'h0, adr(i, 1'h1), 32'h0000_0000, 4'h0);
            chk("rx reset", 32'h0000_0020, rd);
            chk_err("reset read err", 1'h0, er);
            chk_ctl("lane reset", exp_ctl(8'h00, 8'h20), lane_ctl[i]);
        end
    endtask
    task t_write;
        for (int i = 0; i < 8; i++) begin
            tp[i] = {i[0], i[1], i[2], i[1] ^ i[0], ~i[0], 3'h0};
            rp[i] = {i[1], i[2], 6'h20};
            apb(1'h1, adr(i, 1'h0), {24'hA5_A5A5, tp[i]}, 4'h1);
            apb(1'h1, adr(i, 1'h1), {24'h5A_5A5A, rp[i]}, 4'hF);
            if (i < 7) chk_ctl("next lane", exp_ctl(8'h00, 8'h20), lane_ctl[i + 1]);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'h0, adr(i, 1'h0), 32'h0000_0000, 4'h0);
            chk("tx read", {24'h00_0000, tp[i]}, rd);
            apb(1'h0, adr(i, 1'h1), 32'h0000_0000, 4'h0);
            chk("rx read", {24'h00_0000, rp[i]}, rd);
            chk_ctl("lane ctl", exp_ctl(tp[i], rp[i]), lane_ctl[i]);
        end
    endtask
    task t_refused;
        apb(1'h1, adr(0, 1'h0), 32'h0000_00F0, 4'h0);
        chk_err("masked err", 1'h0, er);
        apb(1'h1, 20'h0_0000, 32'h0000_00F0, 4'h1);
        chk_err("unmapped err", 1'h1, er);
        chk("write data zero", 32'h0000_0000, rd);
        apb(1'h0, adr(0, 1'h0) + 20'h0_0001, 32'h0000_0000, 4'h0);
        chk_err("unaligned err", 1'h1, er);
        chk("unaligned data", 32'h0000_0000, rd);
        apb(1'h0, adr(0, 1'h0), 32'h0000_0000, 4'h0);
        chk("tx kept", {24'h00_0000, tp[0]}, rd);
        chk_err("kept err", 1'h0, er);
        chk_ctl("lane kept", exp_ctl(tp[0], rp[0]), lane_ctl[0]);
    endtask
    // Reset in mid-run must reload registers that now hold written values
    task t_rereset;
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_write;
        t_refused;
        t_rereset;
        give_verdict;
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        give_verdict;
    end
endmodule
bind slcr_regs slcr_regs_assertions #(.NUM_LANES(NUM_LANES)) slcr_regs_assertions_i (.CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .LANE_CTL_OUT(LANE_CTL_OUT));
`default_nettype wire
